// File: design/hadr_pkg.sv
// Package for the host address decode and routing block.
// Assumes a single 100 MHz system clock and a classic Wishbone register slave.
package hadr_pkg;

  // ---------------------------------------------------------------
  // Register map (word aligned byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MEM_CTRL = 8'h00;
  localparam logic [7:0] OFS_APERTURE = 8'h04;
  localparam logic [7:0] OFS_SHADOW = 8'h08;
  localparam logic [7:0] OFS_TOP_DRAM = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LAST_ROUTE = 8'h14;

  // ---------------------------------------------------------------
  // Field positions in the memory control register
  // ---------------------------------------------------------------
  localparam int MC_APER_64 = 0;
  localparam int MC_HIGH_SMM_SEGMENT_EN = 1;
  localparam int MC_TSEG_EN = 2;
  localparam int MC_TSEG_1M = 3;
  localparam int MC_GMS_LO = 4;
  localparam int MC_VGA_EN = 6;
  localparam int MC_CSMM_OPEN = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_MEM_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_APERTURE = 32'hf800_0000;
  localparam logic [31:0] RST_SHADOW = 32'h0000_0000;
  localparam logic [31:0] RST_TOP_DRAM = 32'h0800_0000;

  // ---------------------------------------------------------------
  // Fixed address ranges
  // ---------------------------------------------------------------
  localparam logic [11:0] APIC_IO_PAGE = 12'hfec;
  localparam logic [11:0] APIC_LOC_PAGE = 12'hfee;
  localparam logic [11:0] GAP_PAGE = 12'hfed;
  localparam logic [10:0] BIOS_TOP_2M = 11'h7ff;
  localparam logic [14:0] HIGH_SMM_SEGMENT_BASE = 15'h7f75;
  localparam logic [31:0] LEGACY_VGA_BASE = 32'h000a_0000;
  localparam logic [31:0] SIZE_512K = 32'h0008_0000;
  localparam logic [31:0] SIZE_1M = 32'h0010_0000;
  localparam logic [31:0] SIZE_32M = 32'h0200_0000;
  localparam logic [31:0] SIZE_64M = 32'h0400_0000;
  localparam logic [15:0] CFG_ADDR_PORT = 16'h0cf8;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0cfc;
  localparam logic [9:0] VGA_MONO_LO = 10'h3b0;
  localparam logic [9:0] VGA_MONO_HI = 10'h3bb;
  localparam logic [9:0] VGA_COLOR_LO = 10'h3c0;
  localparam logic [9:0] VGA_COLOR_HI = 10'h3df;
  localparam logic [9:0] VGA_FWD_PORT = 10'h3bf;

  // ---------------------------------------------------------------
  // Request field encodings
  // ---------------------------------------------------------------
  localparam logic [4:0] REQ_SPECIAL_A = 5'b01000;
  localparam logic [2:0] REQ_SPECIAL_B = 3'b001;
  localparam logic [1:0] SIZE_CODE_OK = 2'b00;
  localparam logic [1:0] LEN_UPTO8 = 2'b00;
  localparam logic [1:0] LEN_16 = 2'b01;
  localparam logic [1:0] LEN_32 = 2'b10;
  localparam logic [1:0] LEN_RSVD = 2'b11;
  localparam logic [7:0] BE_ALL = 8'hff;
  localparam int IOQ_DEPTH = 4;

  // Destination codes, one hot
  typedef enum logic [5:0]
  {
    DST_DRAM = 6'b000001,
    DST_HUB = 6'b000010,
    DST_GFX = 6'b000100,
    DST_LOCAL = 6'b001000,
    DST_CFG = 6'b010000,
    DST_NONE = 6'b100000
  } hadr_dst_t;

  // Request as it enters the decoder
  typedef struct packed
  {
    logic from_hub;
    logic is_io;
    logic is_write;
    logic smm;
    logic io_wrap_addr_bit;
    logic [3:0] addr_hi;
    logic [31:0] addr;
    logic [4:0] request_phase_one;
    logic [4:0] request_phase_two;
    logic [1:0] transfer_length_field;
    logic [7:0] byte_enables;
  } hadr_req_t;

  // Routing decision
  typedef struct packed
  {
    hadr_dst_t dst;
    logic [31:0] addr;
    logic special;
    logic [7:0] special_type;
    logic bad_fields;
    logic wait_done;
  } hadr_route_t;

endpackage

// File: design/hadr_router.sv
// Host address decode and routing block: one request in, one route out.
// Assumes the host side holds at most four outstanding requests and
// takes routes in order; Wishbone classic slave for configuration.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Graphics aperture is 32 or 64 MB at a software base.
// - APIC ranges, every 4 KB I/O APIC unit included, go to the hub.
// - FED0_0000h page between the I/O and local APIC pages always goes to the hub for host cycles; hub cycles are not claimed.
// - Top 2 MB of 4 GB goes to the hub for boot firmware.
// - Enabled high segment FEEA_0000h-FEEB_FFFFh maps onto DRAM at A0000h for SMM cycles.
// - SMM memory below 1 MB, above 1 MB, and top segment of 512 KB or 1 MB.
// - Shadow regions route reads and writes by separate per-region attributes.
// - I/O not hitting config ports or graphics legacy I/O goes to hub.
// - Config address and data ports are decoded internally.
// - I/O addresses pass unchanged; wrap bit gives 64K+3 locations.
// - Disk I/O writes are never posted; finish after downstream completes.
// - I/O cycles from the hub are ignored and not claimed.
// - Hub memory cycles accepted only for system or graphics memory.
// - VGA I/O 3B0h-3BBh, 3C0h-3DFh, A[15:10] ignored, steered by select bits.
// - I/O to 3BFh from the host always goes to the hub.
// - Up to four outstanding requests tracked in order.
// - Requests complete strictly in arrival order.
// - Data size field is 00, a 64-bit bus.
// - Length 00 up to 8 bytes, 01 is 16, 10 is 32, 11 reserved.
// - Special cycle: phase one 01000, phase two xx001, type from A[15:8].
// - Above 4 GB terminated locally; writes dropped, reads return zero.
// - Unclaimed addresses from top of DRAM to 4 GB go to the hub.
module hadr_router
  import hadr_pkg::*;
#(
  parameter int QDEPTH = IOQ_DEPTH
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Request side
  input wire logic req_valid_i,
  input wire hadr_req_t req_i,
  output logic req_ready_o,
  // Completion of the oldest routed request by its target
  input wire logic done_i,
  // Disk-interface hit on an I/O write, from the downstream decoder
  input wire logic io_disk_hit_i,
  // Route side
  output logic route_valid_o,
  output hadr_route_t route_o,
  output logic [2:0] queue_count_o
);

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // Release is synchronous to avoid partial reset across the block
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] mem_ctrl_reg;
  logic [31:0] aperture_reg;
  logic [31:0] shadow_reg;
  logic [31:0] top_dram_reg;
  logic [31:0] status_reg;
  logic [31:0] last_route_reg;
  logic wb_hit;

  // Merge write data under byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writable configuration, one access per ack
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      mem_ctrl_reg <= RST_MEM_CTRL;
      aperture_reg <= RST_APERTURE;
      shadow_reg <= RST_SHADOW;
      top_dram_reg <= RST_TOP_DRAM;
    end
    else if (wb_hit && wb_we_i)
    begin
      case (wb_adr_i)
        OFS_MEM_CTRL: mem_ctrl_reg <= lane_merge(mem_ctrl_reg, wb_dat_i, wb_sel_i);
        OFS_APERTURE: aperture_reg <= lane_merge(aperture_reg, wb_dat_i, wb_sel_i);
        OFS_SHADOW: shadow_reg <= lane_merge(shadow_reg, wb_dat_i, wb_sel_i);
        OFS_TOP_DRAM: top_dram_reg <= lane_merge(top_dram_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Ack after one wait state; unmapped reads return zero, writes dropped
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        OFS_MEM_CTRL: wb_dat_o <= mem_ctrl_reg;
        OFS_APERTURE: wb_dat_o <= aperture_reg;
        OFS_SHADOW: wb_dat_o <= shadow_reg;
        OFS_TOP_DRAM: wb_dat_o <= top_dram_reg;
        OFS_STATUS: wb_dat_o <= status_reg;
        OFS_LAST_ROUTE: wb_dat_o <= last_route_reg;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] sz);
    return (a >= lo) && ((a - lo) < sz);
  endfunction

  function automatic logic [1:0] shadow_attr(input logic [31:0] sh,
                                             input logic [31:0] a);
    logic [3:0] idx;
    idx = a[17:14];
    // Sixteen 16 KB segments C0000h-FFFFFh, bit0 read-enable, bit1 write-enable
    return sh[{idx[3:0], 1'b0} +: 2];
  endfunction

  logic tseg_1m;
  logic [31:0] tseg_size;
  logic [31:0] tseg_base;
  logic [31:0] gfx_size;
  logic [31:0] gfx_base;
  logic [31:0] aper_size;
  hadr_route_t dec;
  logic io_vga;

  assign tseg_1m = mem_ctrl_reg[MC_TSEG_1M];
  assign tseg_size = tseg_1m ? SIZE_1M : SIZE_512K;
  assign tseg_base = mem_ctrl_reg[MC_TSEG_EN] ? top_dram_reg - tseg_size : top_dram_reg;
  assign gfx_size = mem_ctrl_reg[MC_GMS_LO+1] ? SIZE_1M : SIZE_512K;
  assign gfx_base = tseg_base - gfx_size;
  assign aper_size = mem_ctrl_reg[MC_APER_64] ? SIZE_64M : SIZE_32M;
  assign io_vga = ((req_i.addr[9:0] >= VGA_MONO_LO) && (req_i.addr[9:0] <= VGA_MONO_HI))
    || ((req_i.addr[9:0] >= VGA_COLOR_LO) && (req_i.addr[9:0] <= VGA_COLOR_HI));

  // ---------------------------------------------------------------
  // Address decode, first match wins in a fixed order
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [1:0] attr;
    logic gms_on;
    attr = shadow_attr(shadow_reg, req_i.addr);
    gms_on = mem_ctrl_reg[MC_GMS_LO] | mem_ctrl_reg[MC_GMS_LO+1];
    dec = '0;
    dec.dst = DST_HUB;
    dec.addr = req_i.addr;
    dec.special = (req_i.request_phase_one == REQ_SPECIAL_A)
      && (req_i.request_phase_two[2:0] == REQ_SPECIAL_B);
    dec.special_type = req_i.addr[15:8];
    dec.bad_fields = (req_i.transfer_length_field == LEN_RSVD)
      || (req_i.request_phase_two[4:3] != SIZE_CODE_OK)
      || ((req_i.transfer_length_field != LEN_UPTO8) && (req_i.byte_enables != BE_ALL));
    if (dec.special)
    begin
      dec.dst = DST_HUB;
    end
    else if (req_i.is_io)
    begin
      if (req_i.from_hub)
      begin
        dec.dst = DST_NONE;
      end
      else if (!req_i.io_wrap_addr_bit && ((req_i.addr[15:0] == CFG_ADDR_PORT)
               || (req_i.addr[15:0] == CFG_DATA_PORT)))
      begin
        dec.dst = DST_CFG;
      end
      else if (req_i.addr[9:0] == VGA_FWD_PORT)
      begin
        dec.dst = DST_HUB;
      end
      else if (io_vga && mem_ctrl_reg[MC_VGA_EN] && gms_on)
      begin
        dec.dst = DST_GFX;
      end
      else
      begin
        dec.dst = DST_HUB;
      end
      // Wrap bit carried as address bit 16, no translation
      dec.addr = {15'h0000, req_i.io_wrap_addr_bit, req_i.addr[15:0]};
    end
    else if (req_i.addr_hi != 4'h0)
    begin
      dec.dst = req_i.from_hub ? DST_NONE : DST_LOCAL;
    end
    else if (req_i.addr[31:20] == APIC_IO_PAGE || req_i.addr[31:20] == APIC_LOC_PAGE)
    begin
      // HIGH_SMM_SEGMENT sits inside the local APIC page and overrides it for SMM cycles when enabled
      if (req_i.addr[31:17] == HIGH_SMM_SEGMENT_BASE && mem_ctrl_reg[MC_HIGH_SMM_SEGMENT_EN] && req_i.smm)
      begin
        dec.dst = DST_DRAM;
        dec.addr = LEGACY_VGA_BASE | {15'h0000, req_i.addr[16:0]};
      end
      else
      begin
        dec.dst = req_i.from_hub ? DST_NONE : DST_HUB;
      end
    end
    else if (req_i.addr[31:20] == GAP_PAGE)
    begin
      dec.dst = req_i.from_hub ? DST_NONE : DST_HUB;
    end
    else if (req_i.addr[31:21] == BIOS_TOP_2M)
    begin
      dec.dst = req_i.from_hub ? DST_NONE : DST_HUB;
    end
    else if (in_rng(req_i.addr, aperture_reg, aper_size))
    begin
      dec.dst = DST_GFX;
    end
    else if (req_i.addr >= top_dram_reg)
    begin
      dec.dst = req_i.from_hub ? DST_NONE : DST_HUB;
    end
    else if (mem_ctrl_reg[MC_TSEG_EN] && req_i.addr >= tseg_base)
    begin
      dec.dst = (req_i.smm && !req_i.from_hub) ? DST_DRAM : DST_HUB;
    end
    else if (gms_on && req_i.addr >= gfx_base)
    begin
      dec.dst = DST_GFX;
    end
    else if (req_i.addr[31:17] == 15'h0005)
    begin
      // A0000h-BFFFFh: SMM open to DRAM, else graphics or hub
      if ((req_i.smm || mem_ctrl_reg[MC_CSMM_OPEN]) && !req_i.from_hub)
      begin
        dec.dst = DST_DRAM;
      end
      else
      begin
        dec.dst = (mem_ctrl_reg[MC_VGA_EN] && gms_on) ? DST_GFX : DST_HUB;
      end
    end
    else if (req_i.addr[31:18] == 14'h0003)
    begin
      // Read enable selects DRAM on reads, write enable on writes
      dec.dst = (req_i.is_write ? attr[1] : attr[0]) ? DST_DRAM : DST_HUB;
    end
    else
    begin
      dec.dst = DST_DRAM;
    end
    if (!dec.special && !req_i.is_io && req_i.from_hub && dec.dst == DST_HUB)
    begin
      dec.dst = DST_NONE;
    end
    // Non-posted disk I/O write waits for the downstream completion
    dec.wait_done = req_i.is_io && req_i.is_write && io_disk_hit_i;
  end

  // ---------------------------------------------------------------
  // In-order queue
  // ---------------------------------------------------------------
  hadr_route_t q_mem [QDEPTH];
  logic [1:0] wr_ptr_reg;
  logic [1:0] rd_ptr_reg;
  logic [2:0] cnt_reg;
  logic push;
  logic pop;

  assign req_ready_o = (cnt_reg < 3'(QDEPTH));
  assign push = req_valid_i && req_ready_o;
  assign pop = route_valid_o && done_i;
  assign route_valid_o = (cnt_reg != 3'h0);
  assign route_o = q_mem[rd_ptr_reg];
  assign queue_count_o = cnt_reg;

  // Storage carries no reset; the count guards stale entries
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      q_mem[wr_ptr_reg] <= dec;
    end
  end

  // Pointers advance one per push and pop, oldest always served first
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      cnt_reg <= cnt_reg + 3'(push) - 3'(pop);
    end
  end

  // ---------------------------------------------------------------
  // Status and last route capture
  // ---------------------------------------------------------------
  // Sticky bit 0 flags a bad size or length field; a status write with lane 0 set clears it,
  // but a new error in the same cycle wins
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      status_reg <= 32'h0000_0000;
      last_route_reg <= 32'h0000_0000;
    end
    else
    begin
      status_reg[31:1] <= {26'h0000000, cnt_reg, 2'b00};
      if (push && dec.bad_fields)
      begin
        status_reg[0] <= 1'b1;
      end
      else if (wb_hit && wb_we_i && wb_adr_i == OFS_STATUS && wb_sel_i[0])
      begin
        status_reg[0] <= 1'b0;
      end
      if (push)
      begin
        last_route_reg <= {16'h0000, dec.special_type, 1'b0, dec.special, dec.dst};
      end
    end
  end

endmodule

`default_nettype wire

// File: bench/hadr_router_asserts.sv
// Checker for the host routing block, watching only its ports.
// Assumes one clock; reset is arst_n_i.
`timescale 1ns/100ps
`default_nettype none
module hadr_router_asserts
  import hadr_pkg::*;
#(
  parameter int QDEPTH = IOQ_DEPTH
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire hadr_req_t req_i,
  input wire logic req_ready_o,
  input wire logic done_i,
  input wire logic route_valid_o,
  input wire hadr_route_t route_o,
  input wire logic [2:0] queue_count_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // ------
  // Steps of a transfer
  // ------
  // Taken into an empty queue, so the route shows next cycle
  sequence s_take;
    req_valid_i && req_ready_o && queue_count_o == 3'h0;
  endsequence
  sequence s_host_mem;
    !req_i.from_hub && !req_i.is_io && req_i.addr_hi == 4'h0;
  endsequence
  sequence s_host_io;
    !req_i.from_hub && req_i.is_io;
  endsequence
  // ------
  // Properties
  // ------
  AST_RDY_LIMIT: assert property (req_ready_o == (queue_count_o < QDEPTH))
    else $error("ready does not follow queue count");
  AST_CNT_STEP: assert property (req_valid_i && req_ready_o && !(route_valid_o && done_i)
    |=> queue_count_o == $past(queue_count_o) + 3'h1)
    else $error("push did not raise count");
  AST_HEAD_HOLD: assert property (route_valid_o && !done_i |=> route_valid_o && $stable(route_o))
    else $error("head route moved before completion");
  AST_FIRST_ROUTE: assert property (s_take |=> route_valid_o)
    else $error("route missing after push");
  AST_GAP_HUB: assert property (s_take ##0 s_host_mem ##0 req_i.addr[31:20] == GAP_PAGE
    |=> route_o.dst == DST_HUB)
    else $error("gap page not sent to hub");
  AST_BIOS_HUB: assert property (s_take ##0 s_host_mem ##0 req_i.addr[31:21] == BIOS_TOP_2M
    |=> route_o.dst == DST_HUB)
    else $error("boot range not sent to hub");
  AST_ABOVE_4G: assert property (s_take ##0 !req_i.from_hub && !req_i.is_io && req_i.addr_hi != 4'h0
    |=> route_o.dst == DST_LOCAL)
    else $error("high access not ended locally");
  AST_HUB_IO: assert property (s_take ##0 req_i.from_hub && req_i.is_io |=> route_o.dst == DST_NONE)
    else $error("hub io cycle claimed");
  AST_CFG_PORT: assert property (s_take ##0 s_host_io ##0 !req_i.io_wrap_addr_bit
    && req_i.addr[15:0] == CFG_ADDR_PORT
    |=> route_o.dst == DST_CFG)
    else $error("config port not decoded");
  AST_FWD_3BF: assert property (s_take ##0 s_host_io ##0 req_i.addr[9:0] == VGA_FWD_PORT
    |=> route_o.dst == DST_HUB)
    else $error("port 3bf not sent to hub");
  AST_SPECIAL: assert property (s_take ##0 req_i.request_phase_one == REQ_SPECIAL_A
    && req_i.request_phase_two[2:0] == REQ_SPECIAL_B
    |=> route_o.special && route_o.special_type == $past(req_i.addr[15:8]))
    else $error("special cycle not identified");
endmodule
bind hadr_router hadr_router_asserts #(.QDEPTH(QDEPTH)) u_chk
(
  .clk_sys_i, .arst_n_i, .req_valid_i, .req_i, .req_ready_o,
  .done_i, .route_valid_o, .route_o, .queue_count_o
);
`default_nettype wire

// File: bench/hadr_tgt_model.sv
// Target side model: completes the oldest route after a latency.
// Assumes the router pops only while a route stands.
`timescale 1ns/100ps
`default_nettype none
module hadr_tgt_model
#(
  parameter int LAT = 2
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic route_valid_i,
  input wire logic stall_i,
  output logic done_o
);
  logic [3:0] wait_reg;
  // Cycles the head has stood, cleared at each pop
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wait_reg <= 4'h0;
    else if (done_o)
      wait_reg <= 4'h0;
    else if (route_valid_i && wait_reg != 4'hf)
      wait_reg <= wait_reg + 4'h1;
  end
  // Only the head is completed, never a younger route
  assign done_o = route_valid_i && !stall_i && (wait_reg >= 4'(LAT));
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Bench for the host routing block: register master, requests, target model.
// Assumes a 100 MHz clock and registered acks.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import hadr_pkg::*;
;
  // ------
  // Signals
  // ------
  logic clk_sys_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic req_valid_i = 1'h0;
  hadr_req_t req_i = '0;
  logic req_ready_o;
  logic done_i;
  logic io_disk_hit_i = 1'h0;
  logic route_valid_o;
  hadr_route_t route_o;
  logic [2:0] queue_count_o;
  logic stall = 1'h0;
  logic [31:0] rd;
  hadr_route_t last;
  hadr_req_t rq;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  hadr_router #(.QDEPTH(IOQ_DEPTH)) u_dut (.clk_sys_i, .arst_n_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_i,
    .req_ready_o, .done_i, .io_disk_hit_i, .route_valid_o, .route_o, .queue_count_o);
  hadr_tgt_model u_tgt (.clk_sys_i, .arst_n_i, .route_valid_i(route_valid_o),
    .stall_i(stall), .done_o(done_i));
  always #5 clk_sys_i = ~clk_sys_i;
  // Watchdog: a hang counts as a mismatch and ends the run
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      results();
    end
  end
  // ------
  // Shared tasks
  // ------
  task automatic results();
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_d(input hadr_dst_t e, input hadr_dst_t g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value dst exp %h got %h", e, g);
    end
  endtask
  // Classic cycle held until ack, released after the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk_w(nm, e, rd);
  endtask
  // Flags are hub, io, write, smm; size fields stay 00 by default
  function automatic hadr_req_t mk(input logic [3:0] f, input logic [31:0] a);
    hadr_req_t r;
    r = '0;
    {r.from_hub, r.is_io, r.is_write, r.smm} = f;
    r.addr = a;
    r.byte_enables = BE_ALL;
    return r;
  endfunction
  task automatic push(input hadr_req_t r, input logic disk);
    @(posedge clk_sys_i);
    req_i <= r;
    io_disk_hit_i <= disk;
    req_valid_i <= 1'h1;
    do @(posedge clk_sys_i); while (req_ready_o !== 1'h1);
    req_valid_i <= 1'h0;
  endtask
  // One request into an empty queue, judged, then drained
  task automatic rr(input hadr_req_t r, input logic disk, input hadr_dst_t e);
    push(r, disk);
    @(negedge clk_sys_i);
    chk_d(e, route_o.dst);
    last = route_o;
    while (queue_count_o !== 3'h0) @(negedge clk_sys_i);
  endtask
  task automatic rt(input logic [4:0] f, input logic [31:0] a, input hadr_dst_t e);
    rr(mk(f[3:0], a), f[4], e);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    rdc("aperture", OFS_APERTURE, RST_APERTURE);
    rdc("top", OFS_TOP_DRAM, RST_TOP_DRAM);
    wb(1'h1, 8'h40, 32'h5a5a_5a5a);
    rdc("unmapped", 8'h40, 32'h0);
  endtask
  task automatic t_mem();
    rt(5'h00, 32'h1000, DST_DRAM);
    rt(5'h02, 32'h07ff_fff8, DST_DRAM);
    rt(5'h00, 32'h0800_0000, DST_HUB);
    rt(5'h00, 32'hfec0_3000, DST_HUB);
    rt(5'h02, 32'hfee0_0000, DST_HUB);
    rt(5'h00, 32'hfed0_0000, DST_HUB);
    rt(5'h02, 32'hffff_fff0, DST_HUB);
    rt(5'h00, 32'hf9ff_fff8, DST_GFX);
    rt(5'h00, 32'hfa00_0000, DST_HUB);
    wb(1'h1, OFS_MEM_CTRL, 32'h1);
    rt(5'h00, 32'hfa00_0000, DST_GFX);
    rq = mk(4'h0, 32'h1000);
    rq.addr_hi = 4'h1;
    rr(rq, 1'h0, DST_LOCAL);
  endtask
  task automatic t_smm();
    wb(1'h1, OFS_MEM_CTRL, 32'h2);
    rt(5'h01, 32'hfeea_0000, DST_DRAM);
    chk_w("high_smm_segment addr", LEGACY_VGA_BASE, last.addr);
    rt(5'h00, 32'hfeea_0000, DST_HUB);
    wb(1'h1, OFS_MEM_CTRL, 32'h4);
    rt(5'h01, 32'h07f8_0000, DST_DRAM);
    rt(5'h00, 32'h07f8_0000, DST_HUB);
    rt(5'h00, 32'h07f7_fff8, DST_DRAM);
    wb(1'h1, OFS_MEM_CTRL, 32'hc);
    rt(5'h00, 32'h07f0_0000, DST_HUB);
    wb(1'h1, OFS_MEM_CTRL, 32'h0);
  endtask
  task automatic t_shadow();
    wb(1'h1, OFS_SHADOW, 32'h2);
    rt(5'h00, 32'h000c_0000, DST_HUB);
    rt(5'h02, 32'h000c_0000, DST_DRAM);
    rt(5'h02, 32'h000c_4000, DST_HUB);
    wb(1'h1, OFS_SHADOW, 32'h1);
    rt(5'h00, 32'h000c_0000, DST_DRAM);
    rt(5'h02, 32'h000c_0000, DST_HUB);
    wb(1'h1, OFS_SHADOW, 32'h0);
  endtask
  task automatic t_io();
    rt(5'h04, 32'h03c0, DST_HUB);
    wb(1'h1, OFS_MEM_CTRL, 32'h50);
    rt(5'h04, 32'h73c0, DST_GFX);
    rt(5'h06, 32'h03b0, DST_GFX);
    rt(5'h04, 32'h03df, DST_GFX);
    rt(5'h04, 32'h03bc, DST_HUB);
    rt(5'h04, 32'h03bf, DST_HUB);
    rt(5'h04, 32'h03e0, DST_HUB);
    rt(5'h04, 32'h0cf8, DST_CFG);
    rt(5'h06, 32'h0cfc, DST_CFG);
    rt(5'h0c, 32'h0cf8, DST_NONE);
    rt(5'h16, 32'h01f0, DST_HUB);
    chk_w("wait", 32'h1, last.wait_done);
    rt(5'h06, 32'h01f0, DST_HUB);
    chk_w("wait", 32'h0, last.wait_done);
    rq = mk(4'h4, 32'hfffd);
    rq.io_wrap_addr_bit = 1'h1;
    rr(rq, 1'h0, DST_HUB);
    chk_w("io addr", 32'h0001_fffd, last.addr);
    wb(1'h1, OFS_MEM_CTRL, 32'h0);
  endtask
  task automatic t_hub();
    rt(5'h08, 32'h1000, DST_DRAM);
    rt(5'h0a, 32'hf800_0000, DST_GFX);
    rt(5'h08, 32'hfed0_0000, DST_NONE);
    rt(5'h0a, 32'h0900_0000, DST_NONE);
  endtask
  task automatic t_fields();
    rq = mk(4'h0, 32'h100);
    rq.transfer_length_field = LEN_32;
    rr(rq, 1'h0, DST_DRAM);
    chk_w("bad", 32'h0, last.bad_fields);
    rq.transfer_length_field = LEN_RSVD;
    rr(rq, 1'h0, DST_DRAM);
    chk_w("bad", 32'h1, last.bad_fields);
    rdc("status", OFS_STATUS, 32'h1);
    wb(1'h1, OFS_STATUS, 32'h1);
    rdc("status", OFS_STATUS, 32'h0);
    rq.transfer_length_field = LEN_16;
    rq.byte_enables = 8'h0f;
    rr(rq, 1'h0, DST_DRAM);
    chk_w("bad", 32'h1, last.bad_fields);
    rq = mk(4'h0, 32'h100);
    rq.request_phase_two = 5'h08;
    rr(rq, 1'h0, DST_DRAM);
    chk_w("bad", 32'h1, last.bad_fields);
    rq = mk(4'h0, 32'h3700);
    rq.request_phase_one = REQ_SPECIAL_A;
    rq.request_phase_two = {2'h0, REQ_SPECIAL_B};
    rr(rq, 1'h0, DST_HUB);
    chk_w("type", 32'h37, last.special_type);
    rdc("last route", OFS_LAST_ROUTE, 32'h0000_3742);
    wb(1'h1, OFS_STATUS, 32'h1);
  endtask
  // Fill the queue with the target stalled, then drain it in order
  task automatic t_queue();
    stall <= 1'h1;
    for (int i = 0; i < 4; i++)
      push(mk(4'h0, 32'(32'h100 * i)), 1'h0);
    @(posedge clk_sys_i);
    req_i <= mk(4'h0, 32'h400);
    req_valid_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk_w("count", 32'h4, 32'(queue_count_o));
    chk_w("ready", 32'h0, 32'(req_ready_o));
    chk_w("head", 32'h0, route_o.addr);
    @(posedge clk_sys_i);
    stall <= 1'h0;
    do @(posedge clk_sys_i); while (req_ready_o !== 1'h1);
    req_valid_i <= 1'h0;
    for (int i = 1; i < 5; i++)
    begin
      @(negedge clk_sys_i);
      chk_w("head", 32'(32'h100 * i), route_o.addr);
      while (done_i !== 1'h1) @(negedge clk_sys_i);
    end
  endtask
  // ------
  // Main sequence
  // ------
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    t_regs();
    t_mem();
    t_smm();
    t_shadow();
    t_io();
    t_hub();
    t_fields();
    t_queue();
    results();
  end
endmodule
`default_nettype wire
